// >>> logic/beq_pkg.sv
package beq_pkg;

  localparam int CNT_W = 32;
  localparam int NUM_CNT = 4;
  localparam int MASK_W = 16;

  // apb byte offsets
  localparam logic [7:0] OFS_BUS_UNIT_SEL = 8'h00;
  localparam logic [7:0] OFS_DATA_ACT_SEL = 8'h04;
  localparam logic [7:0] OFS_CFG_BASE = 8'h10;
  localparam logic [7:0] OFS_CNT_BASE = 8'h20;

  // event select control fields
  localparam int SEL_CODE_HI = 31;
  localparam int SEL_CODE_LO = 25;
  localparam int SEL_MASK_HI = 24;
  localparam int SEL_MASK_LO = 9;
  localparam logic [6:0] CODE_QUEUE_ALLOC = 7'h05;
  localparam logic [6:0] CODE_DATA_ACT = 7'h17;

  // counter config control fields
  localparam int CFG_SRC_HI = 15;
  localparam int CFG_SRC_LO = 13;
  localparam int CFG_EN_BIT = 12;
  localparam int CFG_EDGE_BIT = 24;
  localparam logic [2:0] SRC_DATA_BUSY = 3'h6;
  localparam logic [2:0] SRC_QUEUE = 3'h7;
  localparam int QUEUE_CNT_LIMIT = 2;

  // reset values
  localparam logic [31:0] RST_SEL = 32'h00000000;
  localparam logic [31:0] RST_CFG = 32'h00000000;
  localparam logic [CNT_W-1:0] RST_CNT = 32'h00000000;

  // mask bit positions
  localparam int MB_READY_SELF = 1;
  localparam int MB_READY_OTHER = 2;
  localparam int MB_BUSY_SELF = 4;
  localparam int MB_BUSY_OTHER = 5;
  localparam int MB_KIND_LO = 0;
  localparam int MB_SIZE_LO = 2;
  localparam int MB_IO = 5;
  localparam int MB_LOCK = 6;
  localparam int MB_CACHE = 7;
  localparam int MB_SPLIT = 8;
  localparam int MB_DEMAND = 9;
  localparam int MB_ORDERED = 10;
  localparam int MB_MEM_LO = 11;

  // request kind, size and memory kind encodings
  localparam logic [1:0] KIND_READ = 2'h0;
  localparam logic [1:0] KIND_READ_INV = 2'h1;
  localparam logic [1:0] KIND_WRITE = 2'h2;
  localparam logic [1:0] KIND_WRITEBACK = 2'h3;
  localparam logic [1:0] SIZE_ZERO = 2'h0;
  localparam logic [1:0] SIZE_ONE = 2'h1;
  localparam logic [1:0] SIZE_EIGHT = 2'h3;
  localparam logic [2:0] MEM_UNCACHED = 3'h0;
  localparam logic [2:0] MEM_WCOMBINE = 3'h1;
  localparam logic [2:0] MEM_WTHROUGH = 3'h4;
  localparam logic [2:0] MEM_WPROTECT = 3'h5;
  localparam logic [2:0] MEM_WBACK = 3'h6;

  // busy condition lengths in processor clocks
  localparam logic [2:0] BUSY_SHORT = 3'h2;
  localparam logic [2:0] BUSY_LONG = 3'h4;

  typedef struct packed {
    logic valid;
    logic [1:0] kind;
    logic [1:0] size;
    logic [2:0] mem;
    logic io;
    logic lock;
    logic cache;
    logic split;
    logic demand;
    logic ordered;
  } beq_alloc_s;

  typedef struct packed {
    logic reserve;
    logic full_line;
    logic self_capture;
  } beq_busy_s;

  typedef struct packed {
    logic ready_self_capture;
    logic ready_not_captured;
  } beq_ready_s;

  typedef enum {BUSY_IDLE, BUSY_SELF, BUSY_OTHER} beq_busy_e;

endpackage : beq_pkg

// >>> logic/beq_counter.sv
`timescale 1ns/100ps
module beq_counter (
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // configuration
  input wire logic enable,
  input wire logic edge_mode,
  input wire logic event_in,
  // software load
  input wire logic load,
  input wire logic [beq_pkg::CNT_W-1:0] load_val,
  // count value
  output logic [beq_pkg::CNT_W-1:0] count
);
  import beq_pkg::*;

  logic prev_q;
  logic [CNT_W-1:0] count_q;
  logic hit;

  assign hit = enable && event_in && !(edge_mode && prev_q);
  assign count = count_q;

  ////////////////////////////////////////////////////////////////////
  // previous event level for edge mode
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= 1'b0;
    end else if (ce) begin
      prev_q <= event_in;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // counter, software load wins
  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= RST_CNT;
    end else if (ce) begin
      if (load) begin
        count_q <= load_val;
      end else if (hit) begin
        count_q <= count_q + 32'h00000001;
      end
    end
  end

endmodule : beq_counter

// >>> logic/beq_qualifier.sv
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
module beq_qualifier (
  // clock, reset, enable
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic CE,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // bus event sources
  input wire beq_pkg::beq_busy_s BUSY_IN,
  input wire beq_pkg::beq_ready_s READY_IN,
  input wire beq_pkg::beq_alloc_s ALLOC_IN,
  // qualified conditions
  output logic BUSY_RESERVE_SELF_CAPTURE,
  output logic BUSY_RESERVE_NOT_CAPTURED
);
  import beq_pkg::*;

  logic [31:0] bus_unit_select_ctl_zero_q;
  logic [31:0] data_act_sel_q;
  logic [31:0] cfg_q [NUM_CNT];
  logic [CNT_W-1:0] cnt_val [NUM_CNT];
  logic [NUM_CNT-1:0] cnt_event;
  logic [NUM_CNT-1:0] cnt_load;
  logic [31:0] prdata_q;
  logic [2:0] busy_left_q;
  beq_busy_e busy_st_q;
  logic self_cond;
  logic other_cond;
  logic ready_self;
  logic ready_other;
  logic data_act_event;
  logic queue_event;
  logic wr_en;
  logic setup;
  logic mapped;

  ////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [MASK_W-1:0] mask_of(input logic [31:0] r);
    mask_of = r[SEL_MASK_HI:SEL_MASK_LO];
  endfunction : mask_of

  function automatic logic [6:0] code_of(input logic [31:0] r);
    code_of = r[SEL_CODE_HI:SEL_CODE_LO];
  endfunction : code_of

  function automatic logic alloc_match(input logic [MASK_W-1:0] m, input beq_alloc_s a);
    logic ok;
    ok = a.valid;
    ok = ok && (a.kind == m[MB_KIND_LO+:2]);
    ok = ok && (a.size == m[MB_SIZE_LO+:2]);
    ok = ok && (a.mem == m[MB_MEM_LO+:3]);
    ok = ok && (!m[MB_IO] || a.io);
    ok = ok && (!m[MB_LOCK] || a.lock);
    ok = ok && (!m[MB_CACHE] || a.cache);
    ok = ok && (!m[MB_SPLIT] || a.split);
    ok = ok && (a.demand == m[MB_DEMAND]);
    ok = ok && (!m[MB_ORDERED] || a.ordered);
    alloc_match = ok;
  endfunction : alloc_match

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] base, input int idx);
    is_addr = (a == (base + 8'(idx * 4)));
  endfunction : is_addr

  ////////////////////////////////////////////////////////////////////
  // apb decode
  assign setup = PSEL && !PENABLE;
  assign wr_en = CE && PSEL && PENABLE && PWRITE;
  assign PREADY = CE;
  assign PRDATA = prdata_q;

  always_comb begin
    mapped = (PADDR == OFS_BUS_UNIT_SEL) || (PADDR == OFS_DATA_ACT_SEL);
    for (int i = 0; i < NUM_CNT; i++) begin
      mapped = mapped || is_addr(PADDR, OFS_CFG_BASE, i) || is_addr(PADDR, OFS_CNT_BASE, i);
    end
  end

  assign PSLVERR = PSEL && PENABLE && !mapped;

  ////////////////////////////////////////////////////////////////////
  // event select controls
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      bus_unit_select_ctl_zero_q <= RST_SEL;
    end else if (CE && wr_en && PADDR == OFS_BUS_UNIT_SEL) begin
      bus_unit_select_ctl_zero_q <= PWDATA;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      data_act_sel_q <= RST_SEL;
    end else if (CE && wr_en && PADDR == OFS_DATA_ACT_SEL) begin
      data_act_sel_q <= PWDATA;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // counter config controls
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      for (int i = 0; i < NUM_CNT; i++) begin
        cfg_q[i] <= RST_CFG;
      end
    end else if (CE && wr_en) begin
      for (int i = 0; i < NUM_CNT; i++) begin
        if (is_addr(PADDR, OFS_CFG_BASE, i)) begin
          cfg_q[i] <= PWDATA;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data captured in setup phase
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      prdata_q <= 32'h00000000;
    end else if (CE && setup) begin
      prdata_q <= 32'h00000000;
      if (PADDR == OFS_BUS_UNIT_SEL) begin
        prdata_q <= bus_unit_select_ctl_zero_q;
      end
      if (PADDR == OFS_DATA_ACT_SEL) begin
        prdata_q <= data_act_sel_q;
      end
      for (int i = 0; i < NUM_CNT; i++) begin
        if (is_addr(PADDR, OFS_CFG_BASE, i)) begin
          prdata_q <= cfg_q[i];
        end
        if (is_addr(PADDR, OFS_CNT_BASE, i)) begin
          prdata_q <= cnt_val[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // busy reservation condition generator
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      busy_st_q <= BUSY_IDLE;
      busy_left_q <= 3'h0;
    end else if (CE) begin
      if (BUSY_IN.reserve) begin
        // stall repeat restarts the condition
        if (BUSY_IN.self_capture) begin
          if (BUSY_IN.full_line) begin
            busy_st_q <= BUSY_SELF;
            busy_left_q <= BUSY_SHORT;
          end else begin
            busy_st_q <= BUSY_IDLE;
            busy_left_q <= 3'h0;
          end
        end else begin
          busy_st_q <= BUSY_OTHER;
          busy_left_q <= BUSY_IN.full_line ? BUSY_LONG : BUSY_SHORT;
        end
      end else begin
        case (busy_st_q)
          BUSY_SELF, BUSY_OTHER: begin
            if (busy_left_q <= 3'h1) begin
              busy_st_q <= BUSY_IDLE;
              busy_left_q <= 3'h0;
            end else begin
              busy_left_q <= busy_left_q - 3'h1;
            end
          end
          default: begin
            busy_st_q <= BUSY_IDLE;
            busy_left_q <= 3'h0;
          end
        endcase
      end
    end
  end

  // one state, so the two can never both hold
  assign self_cond = (busy_st_q == BUSY_SELF);
  assign other_cond = (busy_st_q == BUSY_OTHER);
  assign BUSY_RESERVE_SELF_CAPTURE = self_cond;
  assign BUSY_RESERVE_NOT_CAPTURED = other_cond;

  // self capture wins when both ready inputs rise
  assign ready_self = READY_IN.ready_self_capture;
  assign ready_other = READY_IN.ready_not_captured && !READY_IN.ready_self_capture;

  ////////////////////////////////////////////////////////////////////
  // event qualification
  always_comb begin
    logic [MASK_W-1:0] dm;
    dm = mask_of(data_act_sel_q);
    data_act_event = 1'b0;
    if (code_of(data_act_sel_q) == CODE_DATA_ACT) begin
      data_act_event = (dm[MB_BUSY_SELF] && self_cond)
        || (dm[MB_BUSY_OTHER] && other_cond)
        || (dm[MB_READY_SELF] && ready_self)
        || (dm[MB_READY_OTHER] && ready_other);
    end
  end

  assign queue_event = (code_of(bus_unit_select_ctl_zero_q) == CODE_QUEUE_ALLOC)
    && alloc_match(mask_of(bus_unit_select_ctl_zero_q), ALLOC_IN);

  always_comb begin
    for (int i = 0; i < NUM_CNT; i++) begin
      cnt_event[i] = 1'b0;
      cnt_load[i] = wr_en && is_addr(PADDR, OFS_CNT_BASE, i);
      case (cfg_q[i][CFG_SRC_HI:CFG_SRC_LO])
        SRC_DATA_BUSY: begin
          cnt_event[i] = data_act_event;
        end
        SRC_QUEUE: begin
          cnt_event[i] = (i < QUEUE_CNT_LIMIT) && queue_event;
        end
        default: begin
          cnt_event[i] = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // counters
  for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
    beq_counter u_cnt (
      .clk(MCLK),
      .rst(SRST),
      .ce(CE),
      .enable(cfg_q[g][CFG_EN_BIT]),
      .edge_mode(cfg_q[g][CFG_EDGE_BIT]),
      .event_in(cnt_event[g]),
      .load(cnt_load[g]),
      .load_val(PWDATA),
      .count(cnt_val[g])
    );
  end

endmodule : beq_qualifier

// >>> test/beq_qualifier_chk.sv
`timescale 1ns/100ps
module beq_qualifier_chk (
  // clock and reset
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic CE,
  // apb status
  input wire logic PSLVERR,
  // bus events and conditions
  input wire beq_pkg::beq_busy_s BUSY_IN,
  input wire logic BUSY_RESERVE_SELF_CAPTURE,
  input wire logic BUSY_RESERVE_NOT_CAPTURED
);
  import beq_pkg::*;
  logic self_c;
  logic oth_c;
  logic rs;
  logic quiet;
  assign self_c = BUSY_RESERVE_SELF_CAPTURE;
  assign oth_c = BUSY_RESERVE_NOT_CAPTURED;
  assign rs = BUSY_IN.reserve & CE;
  assign quiet = ~BUSY_IN.reserve & CE;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);
  ////////////////////////////////////////////////////////////////
  property p_excl; !(self_c && oth_c); endproperty
  a_excl: assert property (p_excl) else $error("both busy conditions high");
  property p_self_full; rs && BUSY_IN.self_capture && BUSY_IN.full_line |=> self_c[*2]; endproperty
  a_self_full: assert property (p_self_full) else $error("self condition short");
  property p_self_end; rs && BUSY_IN.self_capture && BUSY_IN.full_line ##1 quiet[*2] |=> !self_c;
  endproperty
  a_self_end: assert property (p_self_end) else $error("self condition long");
  property p_self_part; rs && BUSY_IN.self_capture && !BUSY_IN.full_line |=> !self_c; endproperty
  a_self_part: assert property (p_self_part) else $error("self on partial");
  property p_oth_full; rs && !BUSY_IN.self_capture && BUSY_IN.full_line ##1 quiet[*3]
    |=> oth_c && $past(oth_c) && $past(oth_c, 2) && $past(oth_c, 3);
  endproperty
  a_oth_full: assert property (p_oth_full) else $error("other full short");
  property p_oth_part; rs && !BUSY_IN.self_capture && !BUSY_IN.full_line
    |=> oth_c[*2] ##1 (!oth_c || $past(BUSY_IN.reserve) || $past(BUSY_IN.reserve, 2));
  endproperty
  a_oth_part: assert property (p_oth_part) else $error("other partial length");
  property p_self_cause; $rose(self_c) |-> $past(BUSY_IN) == 3'h7 && $past(CE); endproperty
  a_self_cause: assert property (p_self_cause) else $error("self without cause");
  property p_oth_cause; $rose(oth_c) |-> $past(BUSY_IN) inside {3'h4, 3'h6} && $past(CE);
  endproperty
  a_oth_cause: assert property (p_oth_cause) else $error("other without cause");
  cover property (rs && BUSY_IN.self_capture && BUSY_IN.full_line);
  cover property (rs && !BUSY_IN.self_capture && !BUSY_IN.full_line);
  cover property (PSLVERR);
endmodule : beq_qualifier_chk
bind beq_qualifier beq_qualifier_chk chk_i (.MCLK(MCLK), .SRST(SRST), .CE(CE),
  .PSLVERR(PSLVERR), .BUSY_IN(BUSY_IN), .BUSY_RESERVE_SELF_CAPTURE(BUSY_RESERVE_SELF_CAPTURE),
  .BUSY_RESERVE_NOT_CAPTURED(BUSY_RESERVE_NOT_CAPTURED));

// >>> test/beq_far_model.sv
`timescale 1ns/100ps
module beq_far_model (
  // clock
  input wire logic clk,
  // bus agent and queue events
  output beq_pkg::beq_busy_s busy,
  output beq_pkg::beq_ready_s ready,
  output beq_pkg::beq_alloc_s alloc
);
  import beq_pkg::*;
  initial begin
    busy = '0;
    ready = '0;
    alloc = '0;
  end
  ////////////////////////////////////////////////////////////////
  // one-cycle reservation, qualifiers scrambled once released
  task reserve(input logic self_cap, input logic full);
    @(posedge clk);
    busy <= {1'b1, full, self_cap};
    @(posedge clk);
    busy <= {1'b0, ~full, ~self_cap};
  endtask : reserve
  // one-cycle data ready levels
  task pulse_ready(input logic self_cap, input logic other);
    @(posedge clk);
    ready <= {self_cap, other};
    @(posedge clk);
    ready <= '0;
  endtask : pulse_ready
  // one-cycle queue allocation
  task put(input beq_alloc_s a);
    @(posedge clk);
    alloc <= a;
    @(posedge clk);
    alloc <= {1'b0, ~a[12:0]};
  endtask : put
endmodule : beq_far_model

// >>> test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import beq_pkg::*;
  logic mclk = 0, srst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, b_self, b_oth, err;
  beq_busy_s busy;
  beq_ready_s ready;
  beq_alloc_s alloc;
  int errors = 0;
  int checks_done = 0;
  logic [31:0] rd;
  always #25 mclk = ~mclk;
  beq_far_model beq_far_model_i (.clk(mclk), .busy(busy), .ready(ready), .alloc(alloc));
  beq_qualifier beq_qualifier_i (.MCLK(mclk), .SRST(srst), .CE(ce), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .BUSY_IN(busy), .READY_IN(ready), .ALLOC_IN(alloc),
    .BUSY_RESERVE_SELF_CAPTURE(b_self), .BUSY_RESERVE_NOT_CAPTURED(b_oth));
  ////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : xfer
  task rdc(input int n, input logic [31:0] e);
    repeat (6) @(posedge mclk);
    xfer(0, OFS_CNT_BASE + 8'(4 * n), 0);
    chk($sformatf("counter%0d", n), rd, e);
  endtask : rdc
  function logic [31:0] cfgw(input logic [2:0] s, input logic e);
    return {7'h00, e, 8'h00, s, 13'h1000};
  endfunction : cfgw
  function logic [15:0] mw(input logic [1:0] k, input logic [4:0] a);
    return {2'h0, MEM_WBACK, a[0], 1'b1, a[1], a[2], a[3], a[4], 1'b0, SIZE_EIGHT, k};
  endfunction : mw
  function beq_alloc_s mk(input logic [1:0] k, input logic [2:0] m, input logic d,
                          input logic [4:0] a);
    return {1'b1, k, SIZE_EIGHT, m, a[4:1], d, a[0]};
  endfunction : mk
  ////////////////////////////////////////////////////////////////
  task t_reset;
    xfer(0, OFS_BUS_UNIT_SEL, 0);
    chk("bus unit select", rd, RST_SEL);
    chk("mapped error", {31'h0, err}, 32'h0);
    xfer(0, OFS_CFG_BASE, 0);
    chk("config0", rd, RST_CFG);
    rdc(0, RST_CNT);
    xfer(1, 8'h40, 32'hFFFFFFFF);
    chk("unmapped error", {31'h0, err}, 32'h1);
    xfer(0, 8'h40, 0);
    chk("unmapped read", rd, 32'h0);
    $display("t_reset done");
  endtask : t_reset
  task t_busy;
    xfer(1, OFS_DATA_ACT_SEL, {CODE_DATA_ACT, 16'h0010, 9'h000});
    xfer(1, OFS_CFG_BASE, cfgw(SRC_DATA_BUSY, 1));
    xfer(1, OFS_CFG_BASE + 8'h04, cfgw(SRC_DATA_BUSY, 0));
    beq_far_model_i.reserve(1, 1);
    beq_far_model_i.reserve(0, 1);
    beq_far_model_i.reserve(1, 0);
    rdc(0, 32'h1);
    rdc(1, 32'h2);
    xfer(1, OFS_DATA_ACT_SEL, {CODE_DATA_ACT, 16'h0020, 9'h000});
    xfer(1, OFS_CNT_BASE, 0);
    xfer(1, OFS_CNT_BASE + 8'h04, 0);
    beq_far_model_i.reserve(0, 1);
    rdc(1, 32'h4);
    beq_far_model_i.reserve(0, 0);
    beq_far_model_i.reserve(1, 1);
    rdc(0, 32'h2);
    rdc(1, 32'h6);
    $display("t_busy done");
  endtask : t_busy
  task t_ready_freeze;
    xfer(1, OFS_DATA_ACT_SEL, {CODE_DATA_ACT, 16'h0004, 9'h000});
    xfer(1, OFS_CNT_BASE + 8'h04, 32'h0);
    beq_far_model_i.pulse_ready(1, 1);
    beq_far_model_i.pulse_ready(0, 1);
    rdc(1, 32'h1);
    @(posedge mclk);
    ce <= 1'b0;
    beq_far_model_i.pulse_ready(0, 1);
    chk("ready while frozen", {31'h0, pready}, 32'h0);
    @(posedge mclk);
    ce <= 1'b1;
    rdc(1, 32'h1);
    $display("t_ready_freeze done");
  endtask : t_ready_freeze
  task t_alloc;
    xfer(1, OFS_CFG_BASE, cfgw(SRC_QUEUE, 0));
    xfer(1, OFS_CFG_BASE + 8'h08, cfgw(SRC_QUEUE, 0));
    for (int k = 0; k < 4; k++) begin
      xfer(1, OFS_BUS_UNIT_SEL, {CODE_QUEUE_ALLOC, mw(2'(k), 5'h00), 9'h000});
      xfer(1, OFS_CNT_BASE, 0);
      for (int j = 0; j < 4; j++) beq_far_model_i.put(mk(2'(j), MEM_WBACK, 1, 0));
      beq_far_model_i.put(mk(2'(k), MEM_UNCACHED, 1, 0));
      beq_far_model_i.put(mk(2'(k), MEM_WBACK, 0, 0));
      rdc(0, 32'h1);
    end
    for (int b = 0; b < 5; b++) begin
      xfer(1, OFS_BUS_UNIT_SEL, {CODE_QUEUE_ALLOC, mw(KIND_READ, 5'(1 << b)), 9'h000});
      xfer(1, OFS_CNT_BASE, 0);
      beq_far_model_i.put(mk(KIND_READ, MEM_WBACK, 1, 0));
      beq_far_model_i.put(mk(KIND_READ, MEM_WBACK, 1, 5'(1 << b)));
      rdc(0, 32'h1);
    end
    rdc(2, 32'h0);
    $display("t_alloc done");
  endtask : t_alloc
  task final_report;
    $display("checks_done %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge mclk);
    srst <= 0;
    t_reset;
    t_busy;
    t_ready_freeze;
    t_alloc;
    final_report;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    final_report;
  end
endmodule : tb_top
